// file: core/vid_reference_tracking.sv
// Function
// - table mode picks direct or slewed response
// - monitor code inputs, move reference smoothly in slewed modes
// - direct modes sample codes at 3 MHz
// - accept code after three equal samples
// - direct modes load new code at once
// - slewed modes sample and validate the same
// - slewed modes accept multi-step code changes
// - slew one 6.25 mV step per 330 kHz
// - 8-bit table, 6.25 mV steps, top two off
// - 5-bit table, 11111 off, 25 mV steps
// - 6-bit table, 25 mV then 12.5 mV steps
`timescale 1ns/1ps
`include "vid_map.svh"

module vid_reference_tracking import vid_pkg::*; #(
	parameter int CODE_WIDTH = 8,
	parameter int SAMPLE_DIV = `VID_SAMPLE_DIV,
	parameter int STEP_DIV   = `VID_STEP_DIV
) (
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic [CODE_WIDTH-1:0] voltage_code_inputs,
	input  wire logic [1:0]            table_mode,
	output logic      [8:0]            reference_dac_value,
	output logic                       output_off,
	output logic                       slew_busy,
	output logic                       code_accepted
);

	// ========================================
	// pin synchronisers
	// ========================================
	localparam int PIN_W = CODE_WIDTH + 2;   // code bits plus mode bits

	wire  [PIN_W-1:0] pin_raw;               // asynchronous pin levels
	logic [PIN_W-1:0] pin_s1;                // first stage, read by s2 only
	logic [PIN_W-1:0] pin_s2;                // second stage
	logic [PIN_W-1:0] pin_s3;                // third stage
	logic [PIN_W-1:0] pin_clean;             // level once s2 and s3 agree

	assign pin_raw = {table_mode, voltage_code_inputs};

	// one three-stage chain per pin; a change is taken once s2 and s3 agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					pin_s1[gi]    <= 1'b0;
					pin_s2[gi]    <= 1'b0;
					pin_s3[gi]    <= 1'b0;
					pin_clean[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin
						pin_clean[gi] <= pin_s3[gi];
					end
				end
			end
		end
	endgenerate

	wire [CODE_WIDTH-1:0] code_clean;        // filtered code pins
	wire table_mode_e     mode;              // filtered mode straps

	assign code_clean = pin_clean[CODE_WIDTH-1:0];
	assign mode       = table_mode_e'(pin_clean[PIN_W-1 -: 2]);

	// ========================================
	// rate dividers
	// ========================================
	logic [8:0]  sample_cnt;                 // sample clock divider
	logic [11:0] step_cnt;                   // slew step divider
	logic        sample_tick;                // one cycle per 3 MHz period
	logic        step_tick;                  // one cycle per 330 kHz period

	// same tick in slewed modes
	// the divider free-runs so sample spacing never depends on mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sample_cnt  <= 9'h000;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= (sample_cnt == 9'(SAMPLE_DIV - 1));
			sample_cnt  <= (sample_cnt == 9'(SAMPLE_DIV - 1)) ? 9'h000 : sample_cnt + 9'h001;
		end
	end

	// 330 kHz step tick
	// free-running too: the first step of a slew lands within one period
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			step_cnt  <= 12'h000;
			step_tick <= 1'b0;
		end else begin
			step_tick <= (step_cnt == 12'(STEP_DIV - 1));
			step_cnt  <= (step_cnt == 12'(STEP_DIV - 1)) ? 12'h000 : step_cnt + 12'h001;
		end
	end

	// ========================================
	// code validation
	// ========================================
	wire [CODE_WIDTH-1:0] valid_code;        // last accepted code
	wire                  valid_pulse;       // one cycle on each acceptance

	// any size of change is accepted here
	code_validator #(
		.WIDTH (CODE_WIDTH)
	) u_validator (
		.clk_sys       (clk_sys),
		.nrst          (nrst),
		.sample_tick   (sample_tick),
		.code_in       (code_clean),
		.accepted_code (valid_code),
		.accept_pulse  (valid_pulse)
	);

	// ========================================
	// table decode
	// ========================================
	// returns {off, units}; units are multiples of 6.25 mV
	function automatic logic [9:0] decode_code(input table_mode_e m,
	                                           input logic [7:0] c);
		logic [8:0] c9;
		logic [8:0] c6;
		logic [8:0] c5;
		logic [9:0] res;
		c9  = {1'b0, c};
		c6  = {3'b000, c[5:0]};
		c5  = {4'b0000, c[4:0]};
		res = 10'h000;
		case (m)
			MODE_8BIT: begin
				if (c >= `VID_8B_OFF_CODE) begin
					res = {1'b1, 9'h000};
				end else begin
					res = {1'b0, `VID_8B_BASE - c9};
				end
			end
			MODE_5BIT_SLEW: begin
				if (c[4:0] == `VID_5B_OFF_CODE) begin
					res = {1'b1, 9'h000};
				end else begin
					res = {1'b0, `VID_5B_BASE - (c5 << 2)};
				end
			end
			MODE_6BIT_STEP, MODE_6BIT_SLEW: begin
				if (!c[5]) begin
					res = {1'b0, `VID_5B_BASE - (c6 << 2)};
				end else begin
					res = {1'b0, `VID_6B_LOW_BASE - (c6 << 1)};
				end
			end
			default: begin
				res = {1'b1, 9'h000};
			end
		endcase
		return res;
	endfunction : decode_code

	wire [9:0] decoded;                      // {off, units} of accepted code
	wire       target_off;                   // accepted code means output off
	wire dac_t target_units;                 // accepted code in units
	wire       slewed_mode;                  // mode uses the slewed response

	assign decoded      = decode_code(mode, 8'(valid_code));
	assign target_off   = decoded[9];
	assign target_units = decoded[8:0];

	assign slewed_mode  = (mode == MODE_5BIT_SLEW) || (mode == MODE_6BIT_SLEW);

	// ========================================
	// tracking state machine
	// ========================================
	track_state_e state;                     // current tracking state
	track_state_e next_state;                // state for next cycle
	dac_t         target;                    // latched slew target
	dac_t         next_dac;                  // reference for next cycle
	wire          at_target;                 // reference equals target
	wire          go_up;                     // target above reference

	assign at_target = (reference_dac_value == target);
	assign go_up     = (target > reference_dac_value);

	// next-state and next-reference selection
	// in direct modes the reference only moves on validated codes; in slew it steps on step_tick
	always_comb begin
		next_state = state;
		next_dac   = reference_dac_value;
		case (state)
			// no code accepted since reset: hold off
			ST_WAIT: begin
				if (valid_pulse) begin
					next_state = ST_HOLD;
					next_dac   = target_units;
				end
			end
			ST_HOLD: begin
				if (valid_pulse && !target_off) begin
					if (slewed_mode) begin
						next_state = ST_SLEW;
					end else begin
						next_dac = target_units;
					end
				end
			end
			ST_SLEW: begin
				// off code halts slew
				// the reference stays where the slew stood, as for an off code in hold
				if (valid_pulse && target_off) begin
					next_state = ST_HOLD;
				end else if (at_target && !valid_pulse) begin
					next_state = ST_HOLD;
				end else if (step_tick && !at_target) begin
					next_dac = go_up ? reference_dac_value + `VID_STEP_UNITS
					                 : reference_dac_value - `VID_STEP_UNITS;
				end
			end
			default: begin
				next_state = ST_WAIT;
			end
		endcase
	end

	// registers of the tracking path; all outputs come from here
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state               <= ST_WAIT;
			target              <= 9'h000;
			reference_dac_value <= 9'h000;
			output_off          <= 1'b1;
			slew_busy           <= 1'b0;
			code_accepted       <= 1'b0;
		end else begin
			state               <= next_state;
			reference_dac_value <= next_dac;
			code_accepted       <= valid_pulse;
			slew_busy           <= (next_state == ST_SLEW);
			// an off code keeps the last reference so a later code resumes cleanly
			if (valid_pulse) begin
				output_off <= target_off;
				if (!target_off) begin
					target <= target_units;
				end
			end
		end
	end

endmodule : vid_reference_tracking

// file: core/vid_map.svh
`ifndef VID_MAP_SVH
`define VID_MAP_SVH

// ========================================
// clock and derived rates
// ========================================
// system clock rate in hertz
`define VID_CLK_HZ         100000000
// code sampling clock in hertz
`define VID_SAMPLE_HZ      3000000
// slew stepping clock in hertz
`define VID_STEP_HZ        330000
// cycles per sample tick, rounded down to keep the rate at or above 3 MHz
`define VID_SAMPLE_DIV     (`VID_CLK_HZ / `VID_SAMPLE_HZ)
// cycles per slew step, rounded down
`define VID_STEP_DIV       (`VID_CLK_HZ / `VID_STEP_HZ)

// ========================================
// validation
// ========================================
// equal consecutive samples before a code is accepted
`define VID_STABLE_COUNT   3

// ========================================
// reference scale (units of 6.25 mV)
// ========================================
// 8-bit table: units = 258 - code (code 0xB2 gives 0.5 V)
`define VID_8B_BASE        9'h102
// 5-bit and 6-bit upper half: units = 248 - 4 * code
`define VID_5B_BASE        9'h0F8
// 6-bit lower half: units = 186 - 2 * code
`define VID_6B_LOW_BASE    9'h0BA
// first 8-bit code meaning output off
`define VID_8B_OFF_CODE    8'hFE
// 5-bit code meaning output off
`define VID_5B_OFF_CODE    5'h1F
// one slew increment in units
`define VID_STEP_UNITS     9'h001

`endif

// file: core/vid_pkg.sv
package vid_pkg;

	// ========================================
	// code-table modes
	// ========================================
	// pin encoding 0..3 in declaration order
	typedef enum logic [1:0] {
		MODE_8BIT,
		MODE_6BIT_STEP,
		MODE_5BIT_SLEW,
		MODE_6BIT_SLEW
	} table_mode_e;

	// ========================================
	// tracking states
	// ========================================
	typedef enum logic [1:0] {
		ST_WAIT,
		ST_HOLD,
		ST_SLEW
	} track_state_e;

	// reference code in 6.25 mV units
	typedef logic [8:0] dac_t;

endpackage : vid_pkg

// file: core/code_validator.sv
`timescale 1ns/1ps
`include "vid_map.svh"

module code_validator import vid_pkg::*; #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             sample_tick,
	input  wire logic [WIDTH-1:0] code_in,
	output logic      [WIDTH-1:0] accepted_code,
	output logic                  accept_pulse
);

	// ========================================
	// candidate tracking
	// ========================================
	logic [WIDTH-1:0] candidate;      // value seen on the latest sample
	logic [1:0]       run_len;        // consecutive equal samples, saturating
	logic             have_code;      // an accepted code exists
	logic [1:0]       next_run_len;   // run length including this sample
	wire              same_as_cand;   // sample repeats the candidate
	wire              is_new;         // sample differs from accepted code, or none yet

	assign same_as_cand = (code_in == candidate);
	assign is_new       = (code_in != accepted_code) || !have_code;
	assign next_run_len = !same_as_cand ? 2'd1 :
	                      (run_len == 2'(`VID_STABLE_COUNT)) ? run_len :
	                      run_len + 2'd1;

	// three equal samples
	// the old code stays until the run completes
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			candidate     <= '0;
			run_len       <= 2'd0;
			have_code     <= 1'b0;
			accepted_code <= '0;
			accept_pulse  <= 1'b0;
		end else begin
			accept_pulse <= 1'b0;
			if (sample_tick) begin
				candidate <= code_in;
				run_len   <= next_run_len;
				if (next_run_len == 2'(`VID_STABLE_COUNT) && is_new) begin
					accepted_code <= code_in;
					have_code     <= 1'b1;
					accept_pulse  <= 1'b1;
				end
			end
		end
	end

endmodule : code_validator

// file: bench/vid_tracking_assertions.sv
`timescale 1ns/1ps
// ========================================
// port checker
// ========================================
module vid_tracking_checker #(
	parameter int CODE_WIDTH = 8,
	parameter int SAMPLE_DIV = 33,
	parameter int STEP_DIV   = 303
) (
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic [CODE_WIDTH-1:0] voltage_code_inputs,
	input  wire logic [1:0]            table_mode,
	input  wire logic [8:0]            reference_dac_value,
	input  wire logic                  output_off,
	input  wire logic                  slew_busy,
	input  wire logic                  code_accepted
);
	localparam int STEP_MAX = STEP_DIV + 2;  // longest gap between slew moves
	logic [CODE_WIDTH-1:0] pins_q;           // pins one cycle ago
	int                    held;             // cycles the pins stayed unchanged

	// saturating age of the present pin value
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pins_q <= '0;
			held   <= 0;
		end else begin
			pins_q <= voltage_code_inputs;
			held   <= (voltage_code_inputs != pins_q) ? 0 : ((held < 4000) ? held + 1 : held);
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	// three ticks span two periods, plus the pin chain and two register stages
	// three equal samples first
	a_stable_accept: assert property (code_accepted |-> held >= 2 * SAMPLE_DIV + 5)
		else $error("code accepted before pins settled");
	a_accept_pulse: assert property (code_accepted |=> !code_accepted)
		else $error("accept pulse too long");
	a_direct_load: assert property (
		!table_mode[1] && $changed(reference_dac_value) |-> code_accepted)
		else $error("direct reference moved without accept");
	a_slew_unit: assert property (
		$past(slew_busy) && $changed(reference_dac_value)
		|-> 9'(reference_dac_value - $past(reference_dac_value)) inside {9'h001, 9'h1FF})
		else $error("slew move not one unit");
	// moves spaced by the stepping period, needs STEP_DIV of 9 or more
	a_step_space: assert property (
		$past(slew_busy) && $changed(reference_dac_value)
		|=> $stable(reference_dac_value) [*8])
		else $error("slew moves too close");
	a_slew_moves: assert property (
		slew_busy |-> ##[1:STEP_MAX] ($changed(reference_dac_value) || !slew_busy))
		else $error("slew stalled");
	// slew starts only on an accept
	a_busy_start: assert property ($rose(slew_busy) |-> code_accepted && table_mode[1])
		else $error("slew began without slewed accept");
	a_off_holds: assert property (
		code_accepted && output_off |-> $stable(reference_dac_value))
		else $error("off code moved reference");
	a_off_still: assert property (output_off && !code_accepted |-> !slew_busy)
		else $error("slewing while off");

	c_direct: cover property (code_accepted && !table_mode[1]);
	c_slew_done: cover property ($fell(slew_busy));
	c_off: cover property (code_accepted && output_off);
	c_off_stop: cover property ($fell(slew_busy) && code_accepted && output_off);
endmodule : vid_tracking_checker

bind vid_reference_tracking vid_tracking_checker #(
	.CODE_WIDTH(CODE_WIDTH),
	.SAMPLE_DIV(SAMPLE_DIV),
	.STEP_DIV(STEP_DIV)
) chk_u (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.voltage_code_inputs(voltage_code_inputs),
	.table_mode(table_mode),
	.reference_dac_value(reference_dac_value),
	.output_off(output_off),
	.slew_busy(slew_busy),
	.code_accepted(code_accepted)
);

// file: bench/cpu_code_model.sv
`timescale 1ns/1ps
// ========================================
// processor driving the code pins
// ========================================
module cpu_code_model #(
	parameter int GAP = 40  // step spacing, scaled with the short sample divider
) (
	input  wire logic       clk_sys,
	output logic      [7:0] voltage_code_inputs
);
	initial voltage_code_inputs = 8'hB2;

	// walk or jump to a new code
	task automatic go(input logic [7:0] target, input logic one_step);
		while (voltage_code_inputs !== target) begin
			repeat (one_step ? GAP : 1) @(negedge clk_sys);
			if (!one_step) begin
				voltage_code_inputs = target;
			end else if (voltage_code_inputs < target) begin
				voltage_code_inputs = voltage_code_inputs + 8'h01;
			end else begin
				voltage_code_inputs = voltage_code_inputs - 8'h01;
			end
		end
	endtask : go

	// short glitch, a deliberate processor fault
	task automatic blip(input logic [7:0] code, input int len);
		logic [7:0] keep;
		keep = voltage_code_inputs;
		@(negedge clk_sys);
		voltage_code_inputs = code;
		repeat (len) @(negedge clk_sys);
		voltage_code_inputs = keep;
	endtask : blip
endmodule : cpu_code_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import vid_pkg::*; ;
	// ========================================
	// fixtures
	// ========================================
	localparam int SDIV = 4;   // short sample divider
	localparam int TDIV = 10;  // short step divider
	typedef struct packed {
		table_mode_e mode;
		logic [7:0]  code;
		dac_t        dac;
		logic        off;
	} row_s;
	logic       clk_sys;
	logic       nrst;
	logic [1:0] table_mode;
	logic [7:0] voltage_code_inputs;
	dac_t       reference_dac_value;
	logic       output_off;
	logic       slew_busy;
	logic       code_accepted;
	int         error_cnt;
	int         n_compared;
	int         n;  // cycles spent slewing
	int         s;  // expected slew steps
	row_s       rows [12];
	dac_t       frozen_dac;  // reference when an off code stopped a slew

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	vid_reference_tracking #(
		.CODE_WIDTH(8),
		.SAMPLE_DIV(SDIV),
		.STEP_DIV(TDIV)
	) dut_u (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.voltage_code_inputs(voltage_code_inputs),
		.table_mode(table_mode),
		.reference_dac_value(reference_dac_value),
		.output_off(output_off),
		.slew_busy(slew_busy),
		.code_accepted(code_accepted)
	);

	cpu_code_model #(.GAP(40)) cpu_u (
		.clk_sys(clk_sys),
		.voltage_code_inputs(voltage_code_inputs)
	);

	// ========================================
	// helpers
	// ========================================
	task automatic stop_test();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk_v(input dac_t got, input dac_t exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t reference %h expected %h", $time, got, exp);
		end
	endtask : chk_v

	task automatic chk_b(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_b

	// bounded waits end the run on a hang
	task automatic wait_acc(input int lim);
		int k;
		// pass one edge first, so the pulse of the previous accept is not taken again
		k = 1;
		@(posedge clk_sys);
		#1;
		while (code_accepted !== 1'b1 && k < lim) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		if (code_accepted !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t no accept", $time);
			stop_test();
		end
	endtask : wait_acc

	task automatic wait_idle(input int lim);
		n = 0;
		while (slew_busy !== 1'b0 && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (slew_busy !== 1'b0) begin
			error_cnt++;
			$display("ERROR %0t slew hangs", $time);
			stop_test();
		end
	endtask : wait_idle

	// mode straps change only under reset
	task automatic do_reset(input logic [1:0] mode, input int len);
		@(negedge clk_sys);
		nrst = 1'b0;
		table_mode = mode;
		repeat (len) @(negedge clk_sys);
		chk_v(reference_dac_value, 9'h000);
		chk_b(output_off, 1'b1);
		chk_b(slew_busy | code_accepted, 1'b0);
		nrst = 1'b1;
	endtask : do_reset

	initial rows = '{
		'{MODE_8BIT, 8'hB2, 9'h050, 1'b0}, '{MODE_8BIT, 8'hFD, 9'h005, 1'b0},
		'{MODE_8BIT, 8'hFE, 9'h005, 1'b1}, '{MODE_6BIT_SLEW, 8'hFE, 9'h03E, 1'b0},
		'{MODE_6BIT_SLEW, 8'h20, 9'h07A, 1'b0}, '{MODE_6BIT_SLEW, 8'h00, 9'h0F8, 1'b0},
		'{MODE_5BIT_SLEW, 8'h00, 9'h0F8, 1'b0}, '{MODE_5BIT_SLEW, 8'h1E, 9'h080, 1'b0},
		'{MODE_5BIT_SLEW, 8'h1F, 9'h080, 1'b1}, '{MODE_6BIT_STEP, 8'h1F, 9'h07C, 1'b0},
		'{MODE_6BIT_STEP, 8'h20, 9'h07A, 1'b0}, '{MODE_6BIT_STEP, 8'h3F, 9'h03C, 1'b0}};

	// ========================================
	// sequence
	// ========================================
	initial begin
		nrst = 1'b0;
		table_mode = MODE_8BIT;
		error_cnt = 0;
		n_compared = 0;
		do_reset(MODE_8BIT, 8);
		foreach (rows[i]) begin
			if (rows[i].mode !== table_mode) begin
				do_reset(rows[i].mode, 2);
			end
			cpu_u.go(rows[i].code, !table_mode[1]);
			wait_acc(100);
			wait_idle(2000);
			chk_v(reference_dac_value, rows[i].dac);
			chk_b(output_off, rows[i].off);
			if (i > 0 && rows[i - 1].mode == rows[i].mode && table_mode[1]) begin
				s = int'(rows[i].dac) - int'(rows[i - 1].dac);
				s = (s < 0) ? -s : s;
				chk_b(n >= (s - 1) * TDIV && n <= s * TDIV + 3, 1'b1);
			end
		end
		// a glitch seen by two samples only
		cpu_u.blip(8'h3E, 2 * SDIV);
		n = 0;
		repeat (60) begin
			@(posedge clk_sys);
			#1;
			if (code_accepted === 1'b1) n++;
		end
		chk_b(n == 0, 1'b1);
		chk_v(reference_dac_value, 9'h03C);
		// new target mid-slew continues from the present value
		do_reset(MODE_6BIT_SLEW, 2);
		wait_acc(100);
		cpu_u.go(8'h00, 1'b0);
		wait_acc(100);
		repeat (20 * TDIV) @(negedge clk_sys);
		cpu_u.go(8'h30, 1'b0);
		wait_acc(100);
		wait_idle(2000);
		chk_b(n <= 12 * TDIV, 1'b1);
		chk_v(reference_dac_value, 9'h05A);
		// off code in the middle of a slew stops it where it stands
		do_reset(MODE_5BIT_SLEW, 2);
		wait_acc(100);
		chk_v(reference_dac_value, 9'h0B8);
		cpu_u.go(8'h00, 1'b0);
		wait_acc(100);
		repeat (10 * TDIV) @(negedge clk_sys);
		cpu_u.go(8'h1F, 1'b0);
		wait_acc(100);
		frozen_dac = reference_dac_value;
		chk_b(slew_busy | !output_off, 1'b0);
		repeat (3 * TDIV) @(negedge clk_sys);
		chk_v(reference_dac_value, frozen_dac);
		chk_b(frozen_dac > 9'h0B8 && frozen_dac < 9'h0F8, 1'b1);
		stop_test();
	end
endmodule : tb_top
